//--- core/dotzq_defs.svh
`ifndef DOTZQ_DEFS_SVH
`define DOTZQ_DEFS_SVH

// clock period in ps
`define DOTZQ_TCK_PS 8000
// asynchronous on/off windows in ps
`define DOTZQ_TAONPD_MIN_PS 2000
`define DOTZQ_TAONPD_MAX_PS 8500
`define DOTZQ_TAOFPD_MIN_PS 2000
`define DOTZQ_TAOFPD_MAX_PS 8500
// least times round up, longest times round down, never below one cycle
`define DOTZQ_CYC_UP(ps) ((((ps) + `DOTZQ_TCK_PS - 1) / `DOTZQ_TCK_PS) < 1 ? 1 : (((ps) + `DOTZQ_TCK_PS - 1) / `DOTZQ_TCK_PS))
`define DOTZQ_CYC_DN(ps) (((ps) / `DOTZQ_TCK_PS) < 1 ? 1 : ((ps) / `DOTZQ_TCK_PS))
`define DOTZQ_AONPD_MIN_CYC `DOTZQ_CYC_UP(`DOTZQ_TAONPD_MIN_PS)
`define DOTZQ_AONPD_MAX_CYC `DOTZQ_CYC_DN(`DOTZQ_TAONPD_MAX_PS)
`define DOTZQ_AOFPD_MIN_CYC `DOTZQ_CYC_UP(`DOTZQ_TAOFPD_MIN_PS)
`define DOTZQ_AOFPD_MAX_CYC `DOTZQ_CYC_DN(`DOTZQ_TAOFPD_MAX_PS)
// entry and exit guard times in clocks
`define DOTZQ_TCPDED_CYC 16'h0001
`define DOTZQ_TXPDLL_CYC 16'h000A
`define DOTZQ_TRFC_CYC 16'h0104
// calibration windows in clocks
`define DOTZQ_TZQINIT_CYC 16'h0200
`define DOTZQ_TZQOPER_CYC 16'h0100
`define DOTZQ_TZQCS_CYC 16'h0040
// offsets between write latency and odt latencies
`define DOTZQ_ODTL_SUB 5'h02
`define DOTZQ_ANPD_SUB 5'h01
`define DOTZQ_AL_MAX 5'h1F
`define DOTZQ_PIPE_W 32
`define DOTZQ_FROZEN_BIT 1'b0

`endif

//--- core/dotzq_pkg.sv
package dotzq_pkg;
  typedef enum logic [3:0] {
    DOTZQ_SYNC = 4'b0001,
    DOTZQ_ENTRY = 4'b0010,
    DOTZQ_ASYNC = 4'b0100,
    DOTZQ_EXIT = 4'b1000
  } dotzq_mode_e;

  typedef enum logic [1:0] {
    DOTZQ_CMD_NONE = 2'b00,
    DOTZQ_CMD_ZQCL = 2'b01,
    DOTZQ_CMD_ZQCS = 2'b10,
    DOTZQ_CMD_REF = 2'b11
  } dotzq_cmd_e;

  typedef struct packed {
    logic odt;
    logic cke;
    dotzq_cmd_e cmd;
    logic dll_slow_exit;
    logic [4:0] wl;
  } dotzq_in_s;

  typedef struct packed {
    logic rtt_on;
    logic rtt_changing;
    logic either_resp;
    logic async_mode;
    logic cal_busy;
    logic cal_update;
  } dotzq_out_s;

  typedef struct packed {
    logic [1:0] phase;
    logic [3:0] cnt;
    logic target;
  } dotzq_async_s;
endpackage : dotzq_pkg

//--- core/dotzq_zq_cal.sv
`timescale 1ns/1ps
`include "dotzq_defs.svh"

module dotzq_zq_cal (
  input wire logic clk,
  input wire logic rst_n,
  input wire dotzq_pkg::dotzq_cmd_e cmd,
  output logic busy,
  output logic update
);
  typedef struct packed {
    logic [15:0] cnt;
    logic busy;
    logic update;
    logic init_done;
  } dotzq_zq_s;

  dotzq_zq_s s_r;
  dotzq_zq_s s_nxt;

  always_comb begin
    s_nxt = s_r;
    s_nxt.update = 1'b0;
    if (s_r.busy) begin
      if (s_r.cnt == 16'h0001) begin
        s_nxt.busy = 1'b0;
        s_nxt.update = 1'b1; // results move to the io only at the end
        s_nxt.cnt = 16'h0000;
      end else begin
        s_nxt.cnt = s_r.cnt - 16'h0001;
      end
    end else if (cmd == dotzq_pkg::DOTZQ_CMD_ZQCL) begin
      s_nxt.busy = 1'b1;
      s_nxt.init_done = 1'b1;
      s_nxt.cnt = s_r.init_done ? `DOTZQ_TZQOPER_CYC : `DOTZQ_TZQINIT_CYC;
    end else if (cmd == dotzq_pkg::DOTZQ_CMD_ZQCS) begin
      s_nxt.busy = 1'b1;
      s_nxt.cnt = `DOTZQ_TZQCS_CYC;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign busy = s_r.busy;
  assign update = s_r.update;
endmodule : dotzq_zq_cal

//--- core/dotzq_top.sv
`timescale 1ns/1ps
`include "dotzq_defs.svh"

// Operation
// - frozen dll in power-down selects asynchronous timing
// - asynchronous path skips additive latency
// - async turn-on between its min and max
// - async turn-off between its min and max
// - frozen-dll setting allows either response near entry
// - entry window wl-1 before cke low to tcpded
// - refresh in progress extends entry from sync mode to trfc
// - tanpd start excluded, end points included
// - window turn-on within min/max of both
// - window turn-off within min/max of both
// - exit window from cke high to txpdll, with no lead before cke high
// - overlapping windows merge into one
// - long calibration, tzqinit first then tzqoper
// - short calibration within tzqcs
// - no self-started recalibration after self-refresh
// - data outputs high impedance while calibrating
// - synchronous latency wl-2 both ways

module dotzq_top (
  input wire logic clk,
  input wire logic rst_n,
  input wire dotzq_pkg::dotzq_in_s pins,
  output dotzq_pkg::dotzq_out_s stat,
  output logic dq_oe
);
  typedef struct packed {
    dotzq_pkg::dotzq_mode_e mode;
    logic [`DOTZQ_PIPE_W-1:0] odt_hist;
    logic [`DOTZQ_PIPE_W-1:0] sync_pipe;
    dotzq_pkg::dotzq_async_s as;
    logic cke_d;
    logic [15:0] win_cnt;
    logic [15:0] rfc_cnt;
    logic rtt_on;
    logic rtt_changing;
    logic either;
    logic dq_oe;
    logic async_mode;
    logic cal_busy;
    logic cal_update;
  } dotzq_state_s;

  dotzq_state_s s_r;
  dotzq_state_s s_nxt;
  logic cal_busy;
  logic cal_update;

  function automatic logic [4:0] dotzq_sub(input logic [4:0] wl, input logic [4:0] k);
    dotzq_sub = (wl > k) ? wl - k : 5'h00;
  endfunction : dotzq_sub

  function automatic logic dotzq_pick(input logic [`DOTZQ_PIPE_W-1:0] v, input logic [4:0] idx);
    dotzq_pick = v[idx];
  endfunction : dotzq_pick

  // recalibration only by explicit command, never on self-refresh exit
  dotzq_zq_cal u_cal (
    .clk(clk),
    .rst_n(rst_n),
    .cmd(pins.cmd),
    .busy(cal_busy),
    .update(cal_update)
  );

  logic [4:0] odtl;
  logic [4:0] anpd;
  logic frozen_sel;
  logic odt_ahead;
  logic cke_fall;
  logic cke_rise;
  logic sync_rtt;

  always_comb begin
    odtl = dotzq_sub(pins.wl, `DOTZQ_ODTL_SUB);
    anpd = dotzq_sub(pins.wl, `DOTZQ_ANPD_SUB);
    frozen_sel = (pins.dll_slow_exit == `DOTZQ_FROZEN_BIT);
    cke_fall = s_r.cke_d && !pins.cke;
    cke_rise = !s_r.cke_d && pins.cke;
    // odt seen wl-1 clocks back already rode the synchronous pipe; the
    // tanpd start cycle itself is excluded from the window
    odt_ahead = dotzq_pick(s_r.odt_hist, anpd);
    sync_rtt = dotzq_pick(s_r.sync_pipe, odtl);
  end

  always_comb begin
    s_nxt = s_r;
    s_nxt.cke_d = pins.cke;
    s_nxt.odt_hist = {s_r.odt_hist[`DOTZQ_PIPE_W-2:0], pins.odt};
    s_nxt.sync_pipe = {s_r.sync_pipe[`DOTZQ_PIPE_W-2:0], pins.odt};
    if (pins.cmd == dotzq_pkg::DOTZQ_CMD_REF) begin
      s_nxt.rfc_cnt = `DOTZQ_TRFC_CYC;
    end else if (s_r.rfc_cnt != 16'h0000) begin
      s_nxt.rfc_cnt = s_r.rfc_cnt - 16'h0001;
    end
    if (s_r.win_cnt != 16'h0000) begin
      s_nxt.win_cnt = s_r.win_cnt - 16'h0001;
    end
    case (s_r.mode)
      dotzq_pkg::DOTZQ_SYNC: begin
        if (cke_fall && frozen_sel) begin
          s_nxt.mode = dotzq_pkg::DOTZQ_ENTRY;
          // end point included: count tcpded, or trfc if refresh still runs
          s_nxt.win_cnt = (s_r.rfc_cnt > `DOTZQ_TCPDED_CYC) ? s_r.rfc_cnt : `DOTZQ_TCPDED_CYC;
        end
      end
      dotzq_pkg::DOTZQ_ENTRY: begin
        if (cke_rise) begin
          s_nxt.mode = dotzq_pkg::DOTZQ_EXIT; // merged windows
          s_nxt.win_cnt = (s_r.win_cnt > `DOTZQ_TXPDLL_CYC) ? s_r.win_cnt : `DOTZQ_TXPDLL_CYC;
        end else if (s_r.win_cnt == 16'h0000) begin
          s_nxt.mode = dotzq_pkg::DOTZQ_ASYNC;
        end
      end
      dotzq_pkg::DOTZQ_ASYNC: begin
        if (cke_rise) begin
          s_nxt.mode = dotzq_pkg::DOTZQ_EXIT;
          s_nxt.win_cnt = `DOTZQ_TXPDLL_CYC;
        end
      end
      dotzq_pkg::DOTZQ_EXIT: begin
        if (cke_fall && frozen_sel) begin
          s_nxt.mode = dotzq_pkg::DOTZQ_ENTRY;
          s_nxt.win_cnt = (s_r.win_cnt > `DOTZQ_TCPDED_CYC) ? s_r.win_cnt : `DOTZQ_TCPDED_CYC;
        end else if (s_r.win_cnt == 16'h0000) begin
          s_nxt.mode = dotzq_pkg::DOTZQ_SYNC;
        end
      end
      default: begin
        s_nxt.mode = dotzq_pkg::DOTZQ_SYNC;
      end
    endcase

    // async engine follows the raw odt input, no additive latency
    if (pins.odt != s_r.as.target) begin
      s_nxt.as.target = pins.odt;
      s_nxt.as.phase = 2'b01;
      s_nxt.as.cnt = 4'h0;
    end else if (s_r.as.phase != 2'b00) begin
      s_nxt.as.cnt = s_r.as.cnt + 4'h1;
    end

    s_nxt.rtt_changing = 1'b0;
    s_nxt.either = (s_r.mode == dotzq_pkg::DOTZQ_ENTRY) || (s_r.mode == dotzq_pkg::DOTZQ_EXIT)
                   || (frozen_sel && s_r.mode == dotzq_pkg::DOTZQ_SYNC && !pins.cke
                       && odt_ahead != pins.odt);
    if (s_r.mode == dotzq_pkg::DOTZQ_SYNC) begin
      s_nxt.rtt_on = sync_rtt;
    end else if (s_r.mode == dotzq_pkg::DOTZQ_ASYNC) begin
      // resistor starts moving at min and settles by max
      if (s_r.as.phase != 2'b00) begin
        if (s_r.as.target) begin
          s_nxt.rtt_changing = (s_r.as.cnt >= 4'(`DOTZQ_AONPD_MIN_CYC - 1));
          if (s_r.as.cnt >= 4'(`DOTZQ_AONPD_MAX_CYC - 1)) begin
            s_nxt.rtt_on = 1'b1;
            s_nxt.as.phase = 2'b00;
          end
        end else begin
          s_nxt.rtt_changing = (s_r.as.cnt >= 4'(`DOTZQ_AOFPD_MIN_CYC - 1));
          if (s_r.as.cnt >= 4'(`DOTZQ_AOFPD_MAX_CYC - 1)) begin
            s_nxt.rtt_on = 1'b0;
            s_nxt.as.phase = 2'b00;
          end
        end
      end
    end else begin
      // in a window the first move waits until both paths reach the target, and the
      // settle also waits out the async max, which covers both bounds
      if (sync_rtt == s_r.as.target && s_r.as.phase != 2'b00) begin
        s_nxt.rtt_changing = 1'b1;
      end
      if (sync_rtt == s_r.as.target && s_r.as.cnt >= 4'(`DOTZQ_AONPD_MAX_CYC - 1)) begin
        s_nxt.rtt_on = s_r.as.target;
        s_nxt.as.phase = 2'b00;
      end
    end
    if (cal_busy) begin
      s_nxt.rtt_on = 1'b0; // termination held off while calibrating
    end
    s_nxt.dq_oe = 1'b0; // this block never drives dq; quiet during calibration
    s_nxt.async_mode = (s_nxt.mode == dotzq_pkg::DOTZQ_ASYNC);
    // status trails the engine one clock so every output leaves a flop
    s_nxt.cal_busy = cal_busy;
    s_nxt.cal_update = cal_update;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '{mode: dotzq_pkg::DOTZQ_SYNC, default: '0};
    end else begin
      s_r <= s_nxt;
    end
  end

  // one driver for the whole status word
  assign stat = '{rtt_on: s_r.rtt_on, rtt_changing: s_r.rtt_changing, either_resp: s_r.either,
                  async_mode: s_r.async_mode, cal_busy: s_r.cal_busy, cal_update: s_r.cal_update};
  assign dq_oe = s_r.dq_oe;
endmodule : dotzq_top

//--- bench/dotzq_top_assertions.sv
`timescale 1ns/1ps

module dotzq_top_chk (
  input wire logic clk,
  input wire logic rst_n,
  input wire dotzq_pkg::dotzq_in_s pins,
  input wire dotzq_pkg::dotzq_out_s stat,
  input wire logic dq_oe
);
  logic [9:0] busy_cnt_r;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_cnt_r <= 10'h000;
    end else begin
      busy_cnt_r <= stat.cal_busy ? busy_cnt_r + 10'h001 : 10'h000;
    end
  end

  // a zq command in the cycle right after another is refused, so leave out any cycle after a command
  sequence s_zq_req;
    pins.cmd inside {dotzq_pkg::DOTZQ_CMD_ZQCL, dotzq_pkg::DOTZQ_CMD_ZQCS} && !stat.cal_busy
      && $past(pins.cmd) == dotzq_pkg::DOTZQ_CMD_NONE;
  endsequence
  sequence s_zq_run;
    ##2 stat.cal_busy;
  endsequence

  a_dq_quiet: assert property (!dq_oe) else $error("data output enabled");
  a_zq_start: assert property (s_zq_req |-> s_zq_run)
    else $error("calibration did not start");
  a_zq_end: assert property ($fell(stat.cal_busy) |-> stat.cal_update ##1 !stat.cal_update)
    else $error("no update pulse at window end");
  a_zq_len: assert property
    ($fell(stat.cal_busy) |-> busy_cnt_r inside {10'h040, 10'h100, 10'h200})
    else $error("calibration window length");
  a_async_on: assert property
    (stat.async_mode && !stat.either_resp && $rose(pins.odt) |-> !stat.rtt_on ##[1:2] stat.rtt_on)
    else $error("async turn-on out of window");
  a_async_off: assert property
    (stat.async_mode && !stat.either_resp && $fell(pins.odt) |-> stat.rtt_on ##[1:2] !stat.rtt_on)
    else $error("async turn-off out of window");
  a_entry_win: assert property ($fell(pins.cke) && !pins.dll_slow_exit |-> ##[0:2] stat.either_resp)
    else $error("entry window missing");
  a_exit_win: assert property
    ($rose(pins.cke) && stat.async_mode |-> ##[0:2] stat.either_resp ##1 stat.either_resp [*6])
    else $error("exit window too short");
endmodule : dotzq_top_chk

bind dotzq_top dotzq_top_chk u_chk (.clk(clk), .rst_n(rst_n), .pins(pins), .stat(stat), .dq_oe(dq_oe));

//--- bench/dotzq_ctrl_model.sv
`timescale 1ns/1ps

module dotzq_ctrl_model (
  input wire logic clk,
  input wire dotzq_pkg::dotzq_out_s stat,
  output dotzq_pkg::dotzq_in_s pins
);
  initial pins = {1'b0, 1'b1, dotzq_pkg::DOTZQ_CMD_NONE, 1'b1, 5'h08};

  task automatic set_lines(input logic odt, input logic cke, input logic slow);
    @(negedge clk);
    pins.odt = odt;
    pins.cke = cke;
    pins.dll_slow_exit = slow;
  endtask : set_lines

  // banks are never opened here, so every command finds them precharged
  // a wait that runs out is handed back so the bench can count it
  task automatic send(input dotzq_pkg::dotzq_cmd_e cmd, output logic timed_out);
    int n;
    n = 0;
    while (stat.cal_busy && n < 1000) begin
      @(negedge clk);
      n++;
    end
    timed_out = stat.cal_busy;
    @(negedge clk);
    pins.cmd = cmd;
    if (cmd != dotzq_pkg::DOTZQ_CMD_REF) begin
      pins.cke = 1'b1;
      pins.odt = 1'b0;
    end
    @(negedge clk);
    pins.cmd = dotzq_pkg::DOTZQ_CMD_NONE;
  endtask : send
endmodule : dotzq_ctrl_model

//--- bench/test_dram_odt_mode_and_zq_calibration.sv
`timescale 1ns/1ps
`include "dotzq_defs.svh"

module test_dram_odt_mode_and_zq_calibration;
  localparam int RTT = 5;
  localparam int EITHER = 3;
  localparam int UPD = 0;
  logic clk;
  logic rst_n;
  dotzq_pkg::dotzq_in_s pins;
  dotzq_pkg::dotzq_out_s stat;
  logic dq_oe;
  int fails;
  int samples_checked;

  dotzq_top dut (.clk(clk), .rst_n(rst_n), .pins(pins), .stat(stat), .dq_oe(dq_oe));
  dotzq_ctrl_model ctrl (.clk(clk), .stat(stat), .pins(pins));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic end_sim;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : end_sim

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // edges until a status bit reaches the level, first edge counts one
  task automatic edges_to(input int sel, input logic lvl, output logic [15:0] n);
    n = 16'h0000;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (stat[sel] !== lvl && n < 16'h0400);
    if (n == 16'h0400) begin
      fails++;
      end_sim();
    end
  endtask : edges_to

  task automatic settle(input int cyc);
    repeat (cyc) @(posedge clk);
    #1;
  endtask : settle

  task automatic t_zq(input dotzq_pkg::dotzq_cmd_e cmd, input logic [15:0] len);
    logic [15:0] n;
    logic late;
    ctrl.send(cmd, late);
    check("cal idle wait", {15'h0000, late}, 16'h0000);
    if (late !== 1'b0) begin
      end_sim();
    end
    edges_to(UPD, 1'b1, n);
    // window length plus the status register stage
    check("cal window", n, len + 16'h0001);
    check("dq enable", {15'h0000, dq_oe}, 16'h0000);
    settle(1);
    check("update pulse", {15'h0000, stat.cal_update}, 16'h0000);
  endtask : t_zq

  task automatic t_sync;
    logic [15:0] n;
    ctrl.set_lines(1'b1, 1'b1, 1'b1);
    edges_to(RTT, 1'b1, n);
    // odt latency, plus the output register, plus the first edge counted
    check("sync on", n, 16'(pins.wl) - 16'(`DOTZQ_ODTL_SUB) + 16'h0002);
    ctrl.set_lines(1'b0, 1'b1, 1'b1);
    edges_to(RTT, 1'b0, n);
    check("sync off", n, 16'(pins.wl) - 16'(`DOTZQ_ODTL_SUB) + 16'h0002);
    ctrl.set_lines(1'b0, 1'b0, 1'b1);
    settle(20);
    check("dll kept", {15'h0000, stat.async_mode}, 16'h0000);
    ctrl.set_lines(1'b0, 1'b1, 1'b1);
    settle(20);
  endtask : t_sync

  task automatic t_async;
    logic [15:0] n;
    ctrl.set_lines(1'b0, 1'b0, 1'b0);
    edges_to(EITHER, 1'b1, n);
    check("entry window", {15'h0000, n <= 16'h0002}, 16'h0001);
    settle(20);
    check("frozen", {14'h0000, stat.async_mode, stat.either_resp}, 16'h0002);
    ctrl.set_lines(1'b1, 1'b0, 1'b0);
    edges_to(RTT, 1'b1, n);
    check("async on", n, 16'h0002);
    check("async moving", {15'h0000, stat.rtt_changing}, 16'h0001);
    ctrl.set_lines(1'b0, 1'b0, 1'b0);
    edges_to(RTT, 1'b0, n);
    check("async off", n, 16'h0002);
    ctrl.set_lines(1'b0, 1'b1, 1'b0);
    settle(8);
    check("exit window", {15'h0000, stat.either_resp}, 16'h0001);
    settle(8);
    check("exit done", {14'h0000, stat.async_mode, stat.either_resp}, 16'h0000);
  endtask : t_async

  task automatic t_refresh;
    logic late;
    ctrl.send(dotzq_pkg::DOTZQ_CMD_REF, late);
    check("refresh idle wait", {15'h0000, late}, 16'h0000);
    ctrl.set_lines(1'b0, 1'b0, 1'b0);
    settle(200);
    check("refresh window", {15'h0000, stat.either_resp}, 16'h0001);
    settle(80);
    check("refresh end", {15'h0000, stat.either_resp}, 16'h0000);
    // one clock of cke high: the exit window runs into a fresh entry window
    ctrl.set_lines(1'b0, 1'b1, 1'b0);
    ctrl.set_lines(1'b0, 1'b0, 1'b0);
    settle(8);
    check("merged window", {15'h0000, stat.either_resp}, 16'h0001);
    settle(8);
    check("merged end", {14'h0000, stat.async_mode, stat.either_resp}, 16'h0002);
    ctrl.set_lines(1'b0, 1'b1, 1'b0);
    settle(20);
  endtask : t_refresh

  initial begin
    fails = 0;
    samples_checked = 0;
    rst_n = 1'b0;
    repeat (8) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    t_zq(dotzq_pkg::DOTZQ_CMD_ZQCL, `DOTZQ_TZQINIT_CYC);
    t_zq(dotzq_pkg::DOTZQ_CMD_ZQCL, `DOTZQ_TZQOPER_CYC);
    t_zq(dotzq_pkg::DOTZQ_CMD_ZQCS, `DOTZQ_TZQCS_CYC);
    t_sync();
    t_async();
    t_refresh();
    // a fresh reset must bring back the longer first window
    @(negedge clk);
    rst_n = 1'b0;
    settle(2);
    @(negedge clk);
    rst_n = 1'b1;
    t_zq(dotzq_pkg::DOTZQ_CMD_ZQCL, `DOTZQ_TZQINIT_CYC);
    end_sim();
  end
endmodule : test_dram_odt_mode_and_zq_calibration
